// [include/bmu_pkg.sv]
// package of opcodes, widths and reset values for the bit-manipulation unit
package bmu_pkg;

    // ==========================================================
    // operation codes
    typedef enum logic [4:0] {
        OP_NONE                  = 5'h00,
        OP_COND_BIT_CLEAR        = 5'h01,
        OP_BIT_INVERT            = 5'h02,
        OP_BIT_TEST              = 5'h03,
        OP_CARRY_AND_BIT         = 5'h04,
        OP_CARRY_AND_INV_BIT     = 5'h05,
        OP_CARRY_OR_BIT          = 5'h06,
        OP_CARRY_OR_INV_BIT      = 5'h07,
        OP_CARRY_XOR_BIT         = 5'h08,
        OP_CARRY_XOR_INV_BIT     = 5'h09,
        OP_LOAD_BIT_TO_CARRY     = 5'h0A,
        OP_LOAD_INV_BIT_TO_CARRY = 5'h0B,
        OP_STORE_CARRY_TO_BIT    = 5'h0C,
        OP_STORE_ZERO_TO_BIT     = 5'h0D,
        OP_STORE_INV_CARRY       = 5'h0E,
        OP_STORE_INV_ZERO        = 5'h0F,
        OP_FIELD_EXTRACT         = 5'h10,
        OP_FIELD_INSERT          = 5'h11
    } bmu_op_e;

    // ==========================================================
    // widths and reset values
    localparam int          BIT_NUM_W     = 3;
    localparam logic [7:0]  RESULT_RST    = 8'h00;
    localparam logic        FLAG_RST      = 1'b0;
    localparam int          LATENCY_CYC   = 1;

endpackage

// [rtl/bmu_core.sv]
// single-cycle byte bit-manipulation execution unit
`timescale 1ns/1ns

// Notes on behaviour
// - conditional clear zeroes a memory bit only when zero flag matches selected state
// - conditional clear bit number from 3-bit immediate or register low three bits
// - bit invert flips exactly one bit; number from immediate or register
// - bit test sets zero flag to inverse of the bit; operand untouched
// - carry becomes carry AND bit
// - carry becomes carry AND inverted bit
// - carry becomes carry OR bit
// - carry becomes carry OR inverted bit
// - carry becomes carry XOR bit
// - carry becomes carry XOR inverted bit
// - carry logic, load and store take only the immediate bit number
// - load copies the selected bit into carry
// - inverted load copies the inverted bit into carry
// - carry store writes carry into the bit, other seven bits kept
// - zero store writes zero flag into a memory bit only
// - inverted carry store writes inverted carry into the bit
// - inverted zero store writes inverted zero flag into a memory bit only
// - field extract puts a memory field right-aligned into register low bits
// - field insert writes register low bits into a memory field, rest kept
module bmu_core (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire logic                   op_valid_i,
    input  wire bmu_pkg::bmu_op_e       op_i,
    input  wire logic [7:0]             operand_i,
    input  wire logic                   operand_is_mem_i,
    input  wire logic [2:0]             bit_imm_i,
    input  wire logic [7:0]             bit_reg_i,
    input  wire logic                   use_reg_bit_i,
    input  wire logic                   flag_condition_i,
    input  wire logic [7:0]             field_mask_i,
    input  wire logic [7:0]             reg_data_i,
    input  wire logic                   carry_i,
    input  wire logic                   zero_i,
    output logic                        done_o,
    output logic                        illegal_o,
    output logic [7:0]                  result_o,
    output logic                        result_wr_o,
    output logic                        reg_wr_o,
    output logic                        carry_o,
    output logic                        carry_wr_o,
    output logic                        zero_o,
    output logic                        zero_wr_o
);

    // ==========================================================
    // helpers
    // one-hot mask, bit 0 is the least significant
    function automatic logic [7:0] bit_mask(input logic [2:0] n);
        bit_mask = 8'h01 << n;
    endfunction

    // replace one bit, keeping the other seven
    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] n,
                                           input logic b);
        put_bit = (v & ~bit_mask(n)) | ({8{b}} & bit_mask(n));
    endfunction

    // right-align the masked field: shift by mask's lowest set bit
    function automatic logic [7:0] extract_field(input logic [7:0] v, input logic [7:0] m);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = (v & m) >> i;
            end
        end
        extract_field = r;
    endfunction

    // left-align register low bits into the field position
    function automatic logic [7:0] insert_field(input logic [7:0] v, input logic [7:0] m,
                                                input logic [7:0] d);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                s = d << i;
            end
        end
        insert_field = (v & ~m) | (s & m);
    endfunction

    // ==========================================================
    // state
    logic       done_q, done_d;
    logic       illegal_q, illegal_d;
    logic [7:0] result_q, result_d;
    logic       result_wr_q, result_wr_d;
    logic       reg_wr_q, reg_wr_d;
    logic       carry_q, carry_d;
    logic       carry_wr_q, carry_wr_d;
    logic       zero_q, zero_d;
    logic       zero_wr_q, zero_wr_d;

    logic [2:0] bit_num;
    logic       sel_bit;
    logic       reg_bit_ok;
    logic       mem_only;

    // bit number: register source only allowed for the first three operations
    always_comb begin
        reg_bit_ok = (op_i == bmu_pkg::OP_COND_BIT_CLEAR) || (op_i == bmu_pkg::OP_BIT_INVERT)
                  || (op_i == bmu_pkg::OP_BIT_TEST);
        bit_num    = (use_reg_bit_i && reg_bit_ok) ? bit_reg_i[2:0] : bit_imm_i;
        sel_bit    = operand_i[bit_num];
        mem_only   = (op_i == bmu_pkg::OP_COND_BIT_CLEAR) || (op_i == bmu_pkg::OP_STORE_ZERO_TO_BIT)
                  || (op_i == bmu_pkg::OP_STORE_INV_ZERO) || (op_i == bmu_pkg::OP_FIELD_EXTRACT)
                  || (op_i == bmu_pkg::OP_FIELD_INSERT);
    end

    // next-value decode; illegal forms (register bit number where only immediate
    // is allowed, register operand for memory-only ops) write nothing
    always_comb begin
        done_d      = op_valid_i;
        illegal_d   = 1'b0;
        result_d    = result_q;
        result_wr_d = 1'b0;
        reg_wr_d    = 1'b0;
        carry_d     = carry_q;
        carry_wr_d  = 1'b0;
        zero_d      = zero_q;
        zero_wr_d   = 1'b0;
        if (op_valid_i && ((use_reg_bit_i && !reg_bit_ok) || (mem_only && !operand_is_mem_i))) begin
            illegal_d = 1'b1;
        end else if (op_valid_i) begin
            case (op_i)
                bmu_pkg::OP_COND_BIT_CLEAR: begin
                    if (zero_i == flag_condition_i) begin
                        result_d    = put_bit(operand_i, bit_num, 1'b0);
                        result_wr_d = 1'b1;
                    end
                end
                bmu_pkg::OP_BIT_INVERT: begin
                    result_d    = operand_i ^ bit_mask(bit_num);
                    result_wr_d = 1'b1;
                end
                bmu_pkg::OP_BIT_TEST: begin
                    zero_d    = ~sel_bit;
                    zero_wr_d = 1'b1;
                end
                bmu_pkg::OP_CARRY_AND_BIT: begin
                    carry_d = carry_i & sel_bit;
                    carry_wr_d = 1'b1;
                end
                bmu_pkg::OP_CARRY_AND_INV_BIT: begin
                    carry_d = carry_i & ~sel_bit;
                    carry_wr_d = 1'b1;
                end
                bmu_pkg::OP_CARRY_OR_BIT: begin
                    carry_d = carry_i | sel_bit;
                    carry_wr_d = 1'b1;
                end
                bmu_pkg::OP_CARRY_OR_INV_BIT: begin
                    carry_d = carry_i | ~sel_bit;
                    carry_wr_d = 1'b1;
                end
                bmu_pkg::OP_CARRY_XOR_BIT: begin
                    carry_d = carry_i ^ sel_bit;
                    carry_wr_d = 1'b1;
                end
                bmu_pkg::OP_CARRY_XOR_INV_BIT: begin
                    carry_d = carry_i ^ ~sel_bit;
                    carry_wr_d = 1'b1;
                end
                bmu_pkg::OP_LOAD_BIT_TO_CARRY: begin
                    carry_d = sel_bit;
                    carry_wr_d = 1'b1;
                end
                bmu_pkg::OP_LOAD_INV_BIT_TO_CARRY: begin
                    carry_d = ~sel_bit;
                    carry_wr_d = 1'b1;
                end
                bmu_pkg::OP_STORE_CARRY_TO_BIT: begin
                    result_d    = put_bit(operand_i, bit_num, carry_i);
                    result_wr_d = 1'b1;
                end
                bmu_pkg::OP_STORE_ZERO_TO_BIT: begin
                    result_d    = put_bit(operand_i, bit_num, zero_i);
                    result_wr_d = 1'b1;
                end
                bmu_pkg::OP_STORE_INV_CARRY: begin
                    result_d    = put_bit(operand_i, bit_num, ~carry_i);
                    result_wr_d = 1'b1;
                end
                bmu_pkg::OP_STORE_INV_ZERO: begin
                    result_d    = put_bit(operand_i, bit_num, ~zero_i);
                    result_wr_d = 1'b1;
                end
                bmu_pkg::OP_FIELD_EXTRACT: begin
                    result_d = extract_field(operand_i, field_mask_i);
                    reg_wr_d = 1'b1;
                end
                bmu_pkg::OP_FIELD_INSERT: begin
                    result_d    = insert_field(operand_i, field_mask_i, reg_data_i);
                    result_wr_d = 1'b1;
                end
                default: begin
                    illegal_d = 1'b1;
                end
            endcase
        end
    end

    // registered results: one cycle after the request
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            done_q      <= 1'b0;
            illegal_q   <= 1'b0;
            result_q    <= bmu_pkg::RESULT_RST;
            result_wr_q <= 1'b0;
            reg_wr_q    <= 1'b0;
            carry_q     <= bmu_pkg::FLAG_RST;
            carry_wr_q  <= 1'b0;
            zero_q      <= bmu_pkg::FLAG_RST;
            zero_wr_q   <= 1'b0;
        end else begin
            done_q      <= done_d;
            illegal_q   <= illegal_d;
            result_q    <= result_d;
            result_wr_q <= result_wr_d;
            reg_wr_q    <= reg_wr_d;
            carry_q     <= carry_d;
            carry_wr_q  <= carry_wr_d;
            zero_q      <= zero_d;
            zero_wr_q   <= zero_wr_d;
        end
    end

    assign done_o      = done_q;
    assign illegal_o   = illegal_q;
    assign result_o    = result_q;
    assign result_wr_o = result_wr_q;
    assign reg_wr_o    = reg_wr_q;
    assign carry_o     = carry_q;
    assign carry_wr_o  = carry_wr_q;
    assign zero_o      = zero_q;
    assign zero_wr_o   = zero_wr_q;

    // ==========================================================
    // checks
    property p_cond_clear;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && op_i == bmu_pkg::OP_COND_BIT_CLEAR && operand_is_mem_i
            && !use_reg_bit_i && zero_i != flag_condition_i |=> !result_wr_o;
    endproperty
    a_cond_clear: assert property (p_cond_clear) else $error("clear without condition");

    property p_invert;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && op_i == bmu_pkg::OP_BIT_INVERT && !use_reg_bit_i
            |=> result_wr_o && $countones(result_o ^ $past(operand_i)) == 1;
    endproperty
    a_invert: assert property (p_invert) else $error("invert not one bit");

    property p_test;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && op_i == bmu_pkg::OP_BIT_TEST && !use_reg_bit_i
            |=> zero_wr_o && zero_o == !$past(operand_i[bit_imm_i]) && !result_wr_o;
    endproperty
    a_test: assert property (p_test) else $error("bit test zero wrong");

    property p_and;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && op_i == bmu_pkg::OP_CARRY_AND_BIT && !use_reg_bit_i
            |=> carry_wr_o && carry_o == ($past(carry_i) & $past(operand_i[bit_imm_i]));
    endproperty
    a_and: assert property (p_and) else $error("carry and wrong");

    property p_xor_inv;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && op_i == bmu_pkg::OP_CARRY_XOR_INV_BIT && !use_reg_bit_i
            |=> carry_o == ($past(carry_i) ^ !$past(operand_i[bit_imm_i]));
    endproperty
    a_xor_inv: assert property (p_xor_inv) else $error("carry xor inv wrong");

    property p_imm_only;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && use_reg_bit_i && op_i >= bmu_pkg::OP_CARRY_AND_BIT
            |=> illegal_o && !carry_wr_o && !result_wr_o;
    endproperty
    a_imm_only: assert property (p_imm_only) else $error("register bit number accepted");

    property p_load;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && op_i == bmu_pkg::OP_LOAD_BIT_TO_CARRY && !use_reg_bit_i
            |=> carry_o == $past(operand_i[bit_imm_i]) && !result_wr_o;
    endproperty
    a_load: assert property (p_load) else $error("load bit wrong");

    property p_store;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && op_i == bmu_pkg::OP_STORE_CARRY_TO_BIT && !use_reg_bit_i
            |=> result_o == (($past(operand_i) & ~(8'h01 << $past(bit_imm_i)))
                | ({8{$past(carry_i)}} & (8'h01 << $past(bit_imm_i))));
    endproperty
    a_store: assert property (p_store) else $error("store carry wrong");

    property p_zero_mem;
        @(posedge clk_sys_i) disable iff (rst_i)
        op_valid_i && op_i == bmu_pkg::OP_STORE_ZERO_TO_BIT && !operand_is_mem_i
            |=> illegal_o && !result_wr_o;
    endproperty
    a_zero_mem: assert property (p_zero_mem) else $error("zero store to register");

endmodule // bmu_core

// [tb/bit_manipulation_unit_test.sv]
// self-checking bench for the byte bit-manipulation unit
`timescale 1ns/1ns
module bit_manipulation_unit_test;
    logic             clk_sys_i        = 1'b0;
    logic             rst_i            = 1'b1;
    logic             op_valid_i       = 1'b0;
    bmu_pkg::bmu_op_e op_i             = bmu_pkg::OP_NONE;
    logic [7:0]       operand_i        = 8'h00;
    logic             operand_is_mem_i = 1'b0;
    logic [2:0]       bit_imm_i        = 3'h0;
    logic [7:0]       bit_reg_i        = 8'h00;
    logic             use_reg_bit_i    = 1'b0;
    logic             flag_condition_i = 1'b0;
    logic [7:0]       field_mask_i     = 8'h00;
    logic [7:0]       reg_data_i       = 8'h00;
    logic             carry_i          = 1'b0;
    logic             zero_i           = 1'b0;
    logic             done_o, illegal_o, result_wr_o, reg_wr_o;
    logic             carry_o, carry_wr_o, zero_o, zero_wr_o;
    logic [7:0]       result_o;
    logic [5:0]       pulses;
    int               bad_count        = 0;
    int               n_compared       = 0;

    // 25 MHz system clock
    always #20 clk_sys_i = ~clk_sys_i;

    // pulse order: done, illegal, result write, register write, carry write, zero write
    assign pulses = {done_o, illegal_o, result_wr_o, reg_wr_o, carry_wr_o, zero_wr_o};

    bmu_core dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .operand_i(operand_i), .operand_is_mem_i(operand_is_mem_i), .bit_imm_i(bit_imm_i),
        .bit_reg_i(bit_reg_i), .use_reg_bit_i(use_reg_bit_i),
        .flag_condition_i(flag_condition_i), .field_mask_i(field_mask_i),
        .reg_data_i(reg_data_i), .carry_i(carry_i), .zero_i(zero_i), .done_o(done_o),
        .illegal_o(illegal_o), .result_o(result_o), .result_wr_o(result_wr_o),
        .reg_wr_o(reg_wr_o), .carry_o(carry_o), .carry_wr_o(carry_wr_o), .zero_o(zero_o),
        .zero_wr_o(zero_wr_o)
    );

    // ==========================================================
    // compare tasks, one per kind of result
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_byte(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic cmp_pulses(input string what, input logic [5:0] exp);
        cmp_byte(what, {2'h0, exp}, {2'h0, pulses});
    endtask

    // ==========================================================
    // drive one request at a falling edge; outputs are settled one edge later
    task automatic issue(input bmu_pkg::bmu_op_e op, input logic [7:0] opnd,
                         input logic mem, input logic [2:0] imm);
        @(negedge clk_sys_i);
        op_i             <= op;
        operand_i        <= opnd;
        operand_is_mem_i <= mem;
        bit_imm_i        <= imm;
        op_valid_i       <= 1'b1;
        @(negedge clk_sys_i);
        op_valid_i       <= 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_cond_clear;
        zero_i           = 1'b1;
        flag_condition_i = 1'b1;
        for (int b = 0; b < 8; b++) begin
            issue(bmu_pkg::OP_COND_BIT_CLEAR, 8'hFF, 1'b1, 3'(b));
            cmp_pulses("clear pulses", 6'h28);
            cmp_byte("clear result", 8'hFF & ~(8'h01 << b), result_o);
        end
        zero_i = 1'b0;
        issue(bmu_pkg::OP_COND_BIT_CLEAR, 8'hFF, 1'b1, 3'h2);
        cmp_pulses("clear skipped", 6'h20);
        flag_condition_i = 1'b0;
        use_reg_bit_i    = 1'b1;
        bit_reg_i        = 8'hFD;
        issue(bmu_pkg::OP_COND_BIT_CLEAR, 8'hA7, 1'b1, 3'h0);
        cmp_byte("clear by register", 8'h87, result_o);
        issue(bmu_pkg::OP_COND_BIT_CLEAR, 8'hA7, 1'b0, 3'h0);
        cmp_pulses("clear on register", 6'h30);
        use_reg_bit_i = 1'b0;
    endtask

    task automatic t_invert_test;
        for (int b = 0; b < 8; b++) begin
            issue(bmu_pkg::OP_BIT_INVERT, 8'hA5, 1'b0, 3'(b));
            cmp_pulses("invert pulses", 6'h28);
            cmp_byte("invert result", 8'hA5 ^ (8'h01 << b), result_o);
            issue(bmu_pkg::OP_BIT_TEST, 8'h5A, 1'b1, 3'(b));
            cmp_pulses("test pulses", 6'h21);
            cmp_bit("test zero", ~(8'h5A >> b), zero_o);
        end
        use_reg_bit_i = 1'b1;
        bit_reg_i     = 8'hF3;
        issue(bmu_pkg::OP_BIT_INVERT, 8'hA5, 1'b1, 3'h0);
        cmp_byte("invert by register", 8'hAD, result_o);
        issue(bmu_pkg::OP_BIT_TEST, 8'h08, 1'b0, 3'h0);
        cmp_bit("test by register", 1'b0, zero_o);
        use_reg_bit_i = 1'b0;
    endtask

    // every carry logic and load code, both carry values, both bit values
    task automatic t_carry_logic;
        bmu_pkg::bmu_op_e op;
        logic             v;
        logic             e;
        for (int k = 4; k < 12; k++) begin
            for (int n = 0; n < 4; n++) begin
                op      = bmu_pkg::bmu_op_e'(5'(k));
                carry_i = n[1];
                v       = ~n[0];
                issue(op, 8'h55, n[1], 3'(6 + n[0]));
                case (op)
                    bmu_pkg::OP_CARRY_AND_BIT:     e = carry_i & v;
                    bmu_pkg::OP_CARRY_AND_INV_BIT: e = carry_i & ~v;
                    bmu_pkg::OP_CARRY_OR_BIT:      e = carry_i | v;
                    bmu_pkg::OP_CARRY_OR_INV_BIT:  e = carry_i | ~v;
                    bmu_pkg::OP_CARRY_XOR_BIT:     e = carry_i ^ v;
                    bmu_pkg::OP_CARRY_XOR_INV_BIT: e = carry_i ^ ~v;
                    bmu_pkg::OP_LOAD_BIT_TO_CARRY: e = v;
                    default:                       e = ~v;
                endcase
                cmp_pulses("carry pulses", 6'h22);
                cmp_bit("carry value", e, carry_o);
            end
        end
    endtask

    task automatic t_store;
        carry_i = 1'b1;
        zero_i  = 1'b1;
        issue(bmu_pkg::OP_STORE_CARRY_TO_BIT, 8'h00, 1'b0, 3'h3);
        cmp_byte("store carry", 8'h08, result_o);
        issue(bmu_pkg::OP_STORE_INV_CARRY, 8'hFF, 1'b1, 3'h0);
        cmp_byte("store inverted carry", 8'hFE, result_o);
        issue(bmu_pkg::OP_STORE_ZERO_TO_BIT, 8'h00, 1'b1, 3'h5);
        cmp_byte("store zero", 8'h20, result_o);
        issue(bmu_pkg::OP_STORE_INV_ZERO, 8'hFF, 1'b1, 3'h2);
        cmp_byte("store inverted zero", 8'hFB, result_o);
        cmp_pulses("store pulses", 6'h28);
        carry_i = 1'b0;
        issue(bmu_pkg::OP_STORE_CARRY_TO_BIT, 8'hFF, 1'b1, 3'h7);
        cmp_byte("store carry high", 8'h7F, result_o);
        issue(bmu_pkg::OP_STORE_ZERO_TO_BIT, 8'h00, 1'b0, 3'h1);
        cmp_pulses("zero store on register", 6'h30);
        issue(bmu_pkg::OP_STORE_INV_ZERO, 8'h00, 1'b0, 3'h1);
        cmp_pulses("inverted zero store on register", 6'h30);
        use_reg_bit_i = 1'b1;
        issue(bmu_pkg::OP_CARRY_AND_BIT, 8'hFF, 1'b1, 3'h1);
        cmp_pulses("carry op by register", 6'h30);
        use_reg_bit_i = 1'b0;
    endtask

    task automatic t_field;
        field_mask_i = 8'h38;
        issue(bmu_pkg::OP_FIELD_EXTRACT, 8'hA8, 1'b1, 3'h0);
        cmp_pulses("extract pulses", 6'h24);
        cmp_byte("extract value", 8'h05, result_o);
        field_mask_i = 8'h3C;
        reg_data_i   = 8'h09;
        issue(bmu_pkg::OP_FIELD_INSERT, 8'h5A, 1'b1, 3'h0);
        cmp_pulses("insert pulses", 6'h28);
        cmp_byte("insert value", 8'h66, result_o);
        issue(bmu_pkg::bmu_op_e'(5'h1F), 8'h5A, 1'b1, 3'h0);
        cmp_pulses("unknown code", 6'h30);
    endtask

    // two requests on consecutive edges
    task automatic t_back_to_back;
        carry_i = 1'b1;
        @(negedge clk_sys_i);
        op_i             <= bmu_pkg::OP_STORE_CARRY_TO_BIT;
        operand_i        <= 8'h00;
        operand_is_mem_i <= 1'b1;
        bit_imm_i        <= 3'h7;
        op_valid_i       <= 1'b1;
        @(negedge clk_sys_i);
        cmp_byte("first of pair", 8'h80, result_o);
        // a different operand, so a dropped second request cannot pass unseen
        op_i      <= bmu_pkg::OP_BIT_INVERT;
        operand_i <= 8'h01;
        @(negedge clk_sys_i);
        op_valid_i <= 1'b0;
        cmp_byte("second of pair", 8'h81, result_o);
        cmp_pulses("second pulses", 6'h28);
    endtask

    // ==========================================================
    // verdict and end of run
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // main sequence; every step is a fixed number of edges, so nothing can hang
    initial begin
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        cmp_pulses("pulses in reset", 6'h00);
        cmp_byte("result in reset", 8'h00, result_o);
        rst_i = 1'b0;
        t_cond_clear();
        t_invert_test();
        t_carry_logic();
        t_store();
        t_field();
        t_back_to_back();
        end_of_test();
    end
endmodule // bit_manipulation_unit_test
